// ===== fogl_pkg.sv
// Package: constants for the fail output and alternate pin logic
package fogl_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_GPIO   = 8'h08;
	localparam logic [7:0] ADDR_WAKE   = 8'h0C;
	localparam logic [7:0] ADDR_LEVEL  = 8'h10;
	// Control register fields
	localparam int unsigned CTRL_FORCE   = 0;
	localparam int unsigned CTRL_OVRST   = 1;
	localparam int unsigned CTRL_DUTY_LO = 2;
	localparam int unsigned CTRL_CFG_LO  = 4;
	// Status register fields
	localparam int unsigned ST_FAILURE = 0;
	localparam int unsigned ST_ACTIVE  = 1;
	localparam int unsigned ST_WDC_LO  = 2;
	localparam int unsigned ST_UVC_LO  = 4;
	localparam int unsigned ST_TEST    = 7;
	// Pin function codes
	localparam logic [1:0] PF_FAIL = 2'h0;
	localparam logic [1:0] PF_OFF  = 2'h1;
	localparam logic [1:0] PF_WAKE = 2'h2;
	localparam logic [1:0] PF_SW   = 2'h3;
	localparam logic [1:0] DUTY_RESET = 2'h0;
	localparam logic [1:0] CFG_RESET  = 2'h0;
	// Timing
	localparam int unsigned BLINK_MHZ = 1250;
	localparam int unsigned PULSE_HZ  = 100;
	localparam int unsigned TEST_FILT_US = 64;
	localparam int unsigned BLINK_HALF_CYC = CLK_HZ / BLINK_MHZ * 500;
	localparam int unsigned PULSE_CYC = CLK_HZ / PULSE_HZ;
	localparam int unsigned TEST_FILT_CYC = TEST_FILT_US * (CLK_HZ / 1_000_000);
	localparam int unsigned UV_LIMIT = 4;
	typedef enum logic [4:0] {
		MODE_NORMAL  = 5'b00001,
		MODE_STOP    = 5'b00010,
		MODE_SLEEP   = 5'b00100,
		MODE_RESTART = 5'b01000,
		MODE_FSAFE   = 5'b10000
	} fogl_mode_t;
endpackage : fogl_pkg

// ===== fogl_fail_outputs.sv
// Fail output logic with alternate pin functions and AHB-Lite registers
//
// The register offsets and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/100ps
module fogl_fail_outputs #(
	parameter int unsigned BLINK_HALF = fogl_pkg::BLINK_HALF_CYC,
	parameter int unsigned PULSE_PER  = fogl_pkg::PULSE_CYC,
	parameter int unsigned TEST_FILT  = fogl_pkg::TEST_FILT_CYC
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [7:0]        haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic [31:0]            hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	input  wire fogl_pkg::fogl_mode_t mode,
	input  wire logic [1:0]        config_sel,
	input  wire logic              watchdog_fail,
	input  wire logic              watchdog_trigger_ok,
	input  wire logic              watchdog_off_in_stop,
	input  wire logic              thermal_shutdown_level_two,
	input  wire logic              main_regulator_short,
	input  wire logic              main_regulator_overvoltage,
	input  wire logic              main_regulator_undervoltage,
	input  wire logic              main_regulator_ok,
	output logic                   fail_safe_request,
	output logic                   static_fail_out_n_oe,
	output logic                   blink_fail_out_n_oe,
	output logic                   pulsed_fail_out_n_oe,
	output logic                   second_alt_pin_hs_en,
	output logic                   pulsed_pin_hs_en,
	input  wire logic              second_alt_pin_in,
	input  wire logic              pulsed_fail_or_devmode_pin_in,
	output logic                   test_level
);
	import fogl_pkg::*;

	logic [31:0] ctrl;
	logic [1:0]  wake_status_second;
	logic        failure_flag;
	logic        fail_active;
	logic [1:0]  watchdog_error_count;
	logic [2:0]  uv_count;
	logic        uv_prev;
	logic        wd_prev;
	fogl_mode_t  mode_prev;
	logic        a_pend;
	logic        a_write;
	logic [7:0]  a_addr;
	logic [1:0]  pin_in_prev;
	logic [$clog2(BLINK_HALF+1)-1:0] blink_cnt;
	logic        blink_phase;
	logic [$clog2(PULSE_PER+1)-1:0]  pulse_cnt;
	logic [$clog2(TEST_FILT+1)-1:0]  filt_cnt;

	logic        fail_out_force;
	logic        main_overvoltage_reset_enable;
	logic [1:0]  pulsed_duty_select;
	logic [1:0]  cfg_second;
	logic [1:0]  cfg_third;
	logic        wd_new_fail;
	logic        wd_fires;
	logic        uv_fires;
	logic        fail_event;
	logic        cond_present;
	logic        clear_flag;
	logic        do_write;
	logic [1:0]  eff_second;
	logic [1:0]  eff_third;
	logic        drive_on;
	logic [31:0] pulse_high;
	logic [1:0]  pin_in;
	logic [1:0]  pin_wake_ok;

	assign fail_out_force = ctrl[CTRL_FORCE];
	assign main_overvoltage_reset_enable = ctrl[CTRL_OVRST];
	assign pulsed_duty_select = ctrl[CTRL_DUTY_LO +: 2];
	assign cfg_second = ctrl[CTRL_CFG_LO +: 2];
	assign cfg_third  = ctrl[CTRL_CFG_LO+2 +: 2];
	assign pin_in = {pulsed_fail_or_devmode_pin_in, second_alt_pin_in};

	// Failure events
	always_comb begin
		wd_new_fail = watchdog_fail && !wd_prev;
		// Config 1 fires at first failure, config 2 never fires, 3,4 at second
		if (config_sel[1])
			wd_fires = wd_new_fail && (watchdog_error_count != 2'h0);
		else
			wd_fires = wd_new_fail && (config_sel != 2'h1);
		uv_fires = main_regulator_undervoltage && !uv_prev
			&& (uv_count == 3'(UV_LIMIT - 1));
		cond_present = thermal_shutdown_level_two || main_regulator_short
			|| (main_overvoltage_reset_enable && main_regulator_overvoltage)
			|| (watchdog_error_count != 2'h0);
		fail_event = wd_fires || uv_fires || thermal_shutdown_level_two
			|| main_regulator_short
			|| (main_overvoltage_reset_enable
			&& main_regulator_overvoltage);
	end

	// AHB-Lite slave: zero wait states, always OKAY
	assign do_write = a_pend && a_write;
	assign clear_flag = do_write && (a_addr == ADDR_STATUS)
		&& hwdata[ST_FAILURE];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_pend  <= 1'b0;
			a_write <= 1'b0;
			a_addr  <= 8'h00;
		end else if (hready) begin
			a_pend  <= hsel && htrans[1];
			a_write <= hwrite;
			a_addr  <= haddr;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	always_comb begin
		hrdata = 32'h0000_0000;
		if (a_pend && !a_write) begin
			case (a_addr)
				ADDR_CTRL:   hrdata = {22'h00_0000, ctrl[9:0]};
				ADDR_STATUS: hrdata = {24'h00_0000, test_level, 1'h0,
					uv_count[1:0], watchdog_error_count, fail_active,
					failure_flag};
				ADDR_WAKE:   hrdata = {30'h0000_0000, wake_status_second};
				ADDR_LEVEL:  hrdata = {30'h0000_0000,
					(mode == MODE_NORMAL || mode == MODE_STOP)
					? (pin_in & {cfg_third != PF_FAIL && cfg_third != PF_OFF,
					cfg_second != PF_FAIL && cfg_second != PF_OFF})
					: 2'h0};
				default:     hrdata = 32'h0000_0000;
			endcase
		end
	end

	// Control register; pin functions written only in normal mode
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= {24'h00_0000, CFG_RESET, CFG_RESET, DUTY_RESET, 2'h0};
		end else if (do_write && a_addr == ADDR_CTRL) begin
			ctrl[3:0] <= hwdata[3:0];
			// Bits 9:8 pick high-side over low-side for switch pins
			if (mode == MODE_NORMAL)
				ctrl[9:4] <= hwdata[9:4];
		end
	end

	// Watchdog failure counter and undervoltage counter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			watchdog_error_count <= 2'h0;
			wd_prev <= 1'b0;
			mode_prev <= MODE_NORMAL;
		end else begin
			wd_prev <= watchdog_fail;
			mode_prev <= mode;
			if (wd_new_fail && watchdog_error_count != 2'h3)
				watchdog_error_count <= watchdog_error_count + 2'h1;
			else if (watchdog_trigger_ok
				|| (mode == MODE_SLEEP && mode_prev != MODE_SLEEP)
				|| (mode == MODE_STOP && watchdog_off_in_stop)
				|| (mode == MODE_FSAFE && mode_prev != MODE_FSAFE
				&& !watchdog_fail))
				watchdog_error_count <= 2'h0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			uv_count <= 3'h0;
			uv_prev  <= 1'b0;
		end else begin
			uv_prev <= main_regulator_undervoltage;
			if (main_regulator_undervoltage && !uv_prev)
				uv_count <= uv_fires ? 3'h0 : uv_count + 3'h1;
			else if (main_regulator_ok)
				uv_count <= 3'h0;
		end
	end

	// Failure flag: set wins over clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			failure_flag <= 1'b0;
			fail_active <= 1'b0;
			fail_safe_request <= 1'b0;
		end else begin
			if (fail_event)
				failure_flag <= 1'b1;
			else if (clear_flag && !cond_present)
				failure_flag <= 1'b0;
			// Persists through restart until flag released
			if (fail_event)
				fail_active <= 1'b1;
			else if (!failure_flag && !cond_present)
				fail_active <= 1'b0;
			fail_safe_request <= fail_event && !wd_fires;
		end
	end

	// Force acts independently; release with no failure
	assign drive_on = fail_active || fail_out_force;

	// Effective pin functions per device mode
	always_comb begin
		eff_second = cfg_second;
		eff_third  = cfg_third;
		if (mode == MODE_FSAFE) begin
			if (eff_second != PF_FAIL) eff_second = PF_OFF;
			if (eff_third != PF_FAIL)  eff_third  = PF_OFF;
		end else if (mode == MODE_RESTART) begin
			if (eff_second == PF_SW) eff_second = PF_OFF;
			if (eff_third == PF_SW)  eff_third  = PF_OFF;
		end
		pin_wake_ok = {eff_third == PF_WAKE, eff_second == PF_WAKE};
		pulse_high = PULSE_PER / 5;
		case (pulsed_duty_select)
			2'h1:    pulse_high = PULSE_PER / 10;
			2'h2:    pulse_high = PULSE_PER / 20;
			2'h3:    pulse_high = PULSE_PER / 40;
			default: pulse_high = PULSE_PER / 5;
		endcase
	end

	// Blink and pulse generators run only while active or forced
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			blink_cnt <= '0;
			blink_phase <= 1'b0;
			pulse_cnt <= '0;
		end else if (!drive_on) begin
			blink_cnt <= '0;
			blink_phase <= 1'b0;
			pulse_cnt <= '0;
		end else begin
			if (blink_cnt == ($bits(blink_cnt))'(BLINK_HALF - 1)) begin
				blink_cnt <= '0;
				blink_phase <= ~blink_phase;
			end else
				blink_cnt <= blink_cnt + 1'b1;
			if (pulse_cnt == ($bits(pulse_cnt))'(PULSE_PER - 1))
				pulse_cnt <= '0;
			else
				pulse_cnt <= pulse_cnt + 1'b1;
		end
	end

	// Pin drivers; oe high pulls pin low
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			static_fail_out_n_oe <= 1'b0;
			blink_fail_out_n_oe  <= 1'b0;
			pulsed_fail_out_n_oe <= 1'b0;
			second_alt_pin_hs_en <= 1'b0;
			pulsed_pin_hs_en     <= 1'b0;
		end else begin
			static_fail_out_n_oe <= drive_on;
			blink_fail_out_n_oe <= (eff_second == PF_FAIL)
				? (drive_on && !blink_phase)
				: (eff_second == PF_SW && !ctrl[8]);
			pulsed_fail_out_n_oe <= (eff_third == PF_FAIL)
				? (drive_on && 32'(pulse_cnt) < pulse_high)
				: (eff_third == PF_SW && !ctrl[9]);
			second_alt_pin_hs_en <= eff_second == PF_SW && ctrl[8];
			pulsed_pin_hs_en <= eff_third == PF_SW && ctrl[9];
		end
	end

	// Wake events latched, cleared by writing ones
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wake_status_second <= 2'h0;
			pin_in_prev <= 2'h3;
		end else begin
			pin_in_prev <= pin_in;
			for (int i = 0; i < 2; i++) begin
				if (pin_wake_ok[i] && pin_in[i] != pin_in_prev[i])
					wake_status_second[i] <= 1'b1;
				else if (do_write && a_addr == ADDR_WAKE && hwdata[i])
					wake_status_second[i] <= 1'b0;
			end
		end
	end

	// Test level accepted after stable filter time
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			filt_cnt <= '0;
			test_level <= 1'b1;
		end else if (pulsed_fail_or_devmode_pin_in == test_level)
			filt_cnt <= '0;
		else if (filt_cnt == ($bits(filt_cnt))'(TEST_FILT - 1)) begin
			filt_cnt <= '0;
			test_level <= pulsed_fail_or_devmode_pin_in;
		end else
			filt_cnt <= filt_cnt + 1'b1;
	end

	property p_tsd_activates;
		@(posedge hclk) disable iff (!hresetn)
		thermal_shutdown_level_two |=> fail_active && failure_flag;
	endproperty
	a_tsd_activates: assert property (p_tsd_activates)
		else $error("thermal shutdown did not activate");

	property p_ov_gated;
		@(posedge hclk) disable iff (!hresetn)
		(main_regulator_overvoltage && !main_overvoltage_reset_enable
		&& !fail_active && !fail_event) |=> !fail_active;
	endproperty
	a_ov_gated: assert property (p_ov_gated)
		else $error("overvoltage activated while disabled");

	property p_static_follows;
		@(posedge hclk) disable iff (!hresetn)
		##1 static_fail_out_n_oe == $past(fail_active || fail_out_force);
	endproperty
	a_static_follows: assert property (p_static_follows)
		else $error("static output not following activation");

	property p_failsafe_req;
		@(posedge hclk) disable iff (!hresetn)
		main_regulator_short |=> fail_safe_request;
	endproperty
	a_failsafe_req: assert property (p_failsafe_req)
		else $error("no fail-safe request on short");

	property p_force_release;
		@(posedge hclk) disable iff (!hresetn)
		(!fail_active && !fail_out_force && !fail_event)
		|=> !static_fail_out_n_oe;
	endproperty
	a_force_release: assert property (p_force_release)
		else $error("outputs stay on without cause");

	property p_hold_flag;
		@(posedge hclk) disable iff (!hresetn)
		(failure_flag && cond_present) |=> failure_flag && fail_active;
	endproperty
	a_hold_flag: assert property (p_hold_flag)
		else $error("released while failure present");

	property p_fsafe_switch_off;
		@(posedge hclk) disable iff (!hresetn)
		(mode == MODE_FSAFE) |=> !second_alt_pin_hs_en && !pulsed_pin_hs_en;
	endproperty
	a_fsafe_switch_off: assert property (p_fsafe_switch_off)
		else $error("switch on in fail-safe");

	property p_restart_switch_off;
		@(posedge hclk) disable iff (!hresetn)
		(mode == MODE_RESTART) |=> !second_alt_pin_hs_en;
	endproperty
	a_restart_switch_off: assert property (p_restart_switch_off)
		else $error("switch on in restart");

	property p_cfg_locked;
		@(posedge hclk) disable iff (!hresetn)
		(mode != MODE_NORMAL) |=> $stable(ctrl[9:4]);
	endproperty
	a_cfg_locked: assert property (p_cfg_locked)
		else $error("pin function changed outside normal");

	property p_sleep_clears;
		@(posedge hclk) disable iff (!hresetn)
		(mode == MODE_SLEEP && mode_prev != MODE_SLEEP && !wd_new_fail)
		|=> watchdog_error_count == 2'h0;
	endproperty
	a_sleep_clears: assert property (p_sleep_clears)
		else $error("watchdog count not cleared on sleep");
endmodule // fogl_fail_outputs

// ===== fogl_pin_model.sv
// Lamps, loads and wake sources hanging on the two alternate pins
`timescale 1ns/100ps
module fogl_pin_model (
	input  wire logic blink_fail_out_n_oe,
	input  wire logic pulsed_fail_out_n_oe,
	input  wire logic second_alt_pin_hs_en,
	input  wire logic pulsed_pin_hs_en,
	input  wire logic [1:0] wake_low,
	output logic      second_alt_pin_in,
	output logic      pulsed_fail_or_devmode_pin_in
);
	// Pull-ups keep pins high while undriven, so no dev mode entry
	always_comb begin
		second_alt_pin_in = second_alt_pin_hs_en |
			~(blink_fail_out_n_oe | wake_low[0]);
		pulsed_fail_or_devmode_pin_in = pulsed_pin_hs_en |
			~(pulsed_fail_out_n_oe | wake_low[1]);
	end
endmodule // fogl_pin_model

// ===== tb_fogl.sv
// Self-checking testbench for the fail output and alternate pin logic
`timescale 1ns/100ps
module tb;
	import fogl_pkg::*;
	localparam int unsigned BH = 10;
	localparam int unsigned PP = 200;
	localparam int unsigned TF = 8;
	logic        hclk = 1'h0;
	logic        hresetn = 1'h0;
	logic        hsel = 1'h0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	fogl_mode_t  mode = MODE_NORMAL;
	logic [1:0]  config_sel = 2'h0;
	logic        watchdog_fail = 1'h0;
	logic        watchdog_trigger_ok = 1'h0;
	logic        watchdog_off_in_stop = 1'h0;
	logic [2:0]  src = 3'h0;
	logic        main_regulator_undervoltage = 1'h0;
	logic        main_regulator_ok = 1'h1;
	logic [1:0]  wk = 2'h0;
	logic [31:0] hrdata;
	logic        hreadyout, hresp, fail_safe_request, test_level;
	logic        static_fail_out_n_oe, blink_fail_out_n_oe;
	logic        pulsed_fail_out_n_oe, second_alt_pin_hs_en;
	logic        pulsed_pin_hs_en, second_alt_pin_in;
	logic        pulsed_fail_or_devmode_pin_in;
	int          failures = 0;
	int          comparisons = 0;
	int          cycles = 0;

	fogl_fail_outputs #(.BLINK_HALF(BH), .PULSE_PER(PP), .TEST_FILT(TF))
	u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .mode,
		.config_sel, .watchdog_fail, .watchdog_trigger_ok,
		.watchdog_off_in_stop, .thermal_shutdown_level_two(src[0]),
		.main_regulator_short(src[1]), .main_regulator_overvoltage(src[2]),
		.main_regulator_undervoltage, .main_regulator_ok,
		.fail_safe_request, .static_fail_out_n_oe, .blink_fail_out_n_oe,
		.pulsed_fail_out_n_oe, .second_alt_pin_hs_en, .pulsed_pin_hs_en,
		.second_alt_pin_in, .pulsed_fail_or_devmode_pin_in, .test_level);

	fogl_pin_model u_pins (.blink_fail_out_n_oe, .pulsed_fail_out_n_oe,
		.second_alt_pin_hs_en, .pulsed_pin_hs_en, .wake_low(wk),
		.second_alt_pin_in, .pulsed_fail_or_devmode_pin_in);

	always #5 hclk = ~hclk;

	task automatic test_done;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Hang guard, well above the few thousand cycles the tests need
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			failures++;
			$display("CHECK FAILED t=%0t timeout", $time);
			test_done;
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e,
			input string s);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, s, g, e);
		end
	endtask

	task automatic on(input logic e, input string s);
		chk({31'h0, static_fail_out_n_oe}, {31'h0, e}, s);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask

	// One single transfer; always entered just after a rising edge
	task automatic bus(input logic w, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'h1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		r = hrdata;
		chk({31'h0, hresp}, 32'h0000_0000, "okay");
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'h1, a, d, r);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m,
			input logic [31:0] e, input string s);
		logic [31:0] r;
		bus(1'h0, a, 32'h0000_0000, r);
		chk(r & m, e, s);
	endtask

	task automatic count_high(input logic blink, input int n, output int k);
		k = 0;
		repeat (n) begin
			@(posedge hclk);
			if ((blink ? blink_fail_out_n_oe : pulsed_fail_out_n_oe) === 1'h1)
				k++;
		end
	endtask

	task automatic t_reset;
		rd(ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_0000, "ctrl");
		rd(ADDR_STATUS, 32'h0000_00BF, 32'h0000_0080, "status");
		rd(8'h20, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
		on(1'h0, "idle");
		wk <= 2'h2;
		cyc(TF - 3);
		chk({31'h0, test_level}, 32'h0000_0001, "short low");
		cyc(TF + 4);
		chk({31'h0, test_level}, 32'h0000_0000, "held low");
		wk <= 2'h0;
		cyc(TF + 4);
		$display("test reset done");
	endtask

	task automatic t_force;
		int k;
		int t;
		wr(ADDR_CTRL, 32'h0000_0001);
		cyc(3);
		on(1'h1, "force on");
		for (int p = 0; p < 2; p++) begin
			k = blink_fail_out_n_oe;
			t = 0;
			while (blink_fail_out_n_oe === k[0] && t < 4 * BH) begin
				@(posedge hclk);
				t++;
			end
		end
		chk(32'(t), 32'(BH), "blink half");
		for (int d = 0; d < 4; d++) begin
			wr(ADDR_CTRL, 32'(d * 4 + 1));
			cyc(PP);
			count_high(1'h0, PP, k);
			chk(32'(k), 32'(PP / (5 << d)), "duty");
		end
		rd(ADDR_STATUS, 32'h0000_0001, 32'h0000_0000, "no flag");
		wr(ADDR_CTRL, 32'h0000_0000);
		cyc(3);
		on(1'h0, "force off");
		$display("test force done");
	endtask

	task automatic t_src;
		src <= 3'h4;
		cyc(4);
		on(1'h0, "ov masked");
		chk({31'h0, fail_safe_request}, 32'h0000_0000, "ov no fsafe");
		src <= 3'h0;
		wr(ADDR_CTRL, 32'h0000_0002);
		for (int i = 0; i < 3; i++) begin
			src <= 3'(1 << i);
			cyc(4);
			on(1'h1, "source");
			chk({31'h0, fail_safe_request}, 32'h0000_0001, "fsafe");
			rd(ADDR_STATUS, 32'h0000_0001, 32'h0000_0001, "flag");
			wr(ADDR_CTRL, 32'h0000_0003);
			wr(ADDR_CTRL, 32'h0000_0002);
			wr(ADDR_STATUS, 32'h0000_0001);
			cyc(3);
			on(1'h1, "still failing");
			src <= 3'h0;
			cyc(4);
			on(1'h1, "flag kept");
			chk({31'h0, fail_safe_request}, 32'h0000_0000, "fsafe off");
			wr(ADDR_STATUS, 32'h0000_0001);
			cyc(3);
			on(1'h0, "released");
		end
		wr(ADDR_CTRL, 32'h0000_0000);
		$display("test sources done");
	endtask

	task automatic uv_pulse;
		main_regulator_undervoltage <= 1'h1;
		cyc(3);
		main_regulator_undervoltage <= 1'h0;
		cyc(3);
	endtask

	task automatic t_uv;
		main_regulator_ok <= 1'h0;
		repeat (3) uv_pulse;
		on(1'h0, "three uv");
		rd(ADDR_STATUS, 32'h0000_0030, 32'h0000_0030, "uv count");
		uv_pulse;
		on(1'h1, "fourth uv");
		main_regulator_ok <= 1'h1;
		cyc(3);
		wr(ADDR_STATUS, 32'h0000_0001);
		cyc(3);
		on(1'h0, "uv release");
		$display("test undervoltage done");
	endtask

	task automatic wd_pulse;
		watchdog_fail <= 1'h1;
		cyc(2);
		watchdog_fail <= 1'h0;
		cyc(3);
	endtask

	// Good trigger first, then flag clear, as the controller must do
	task automatic wd_release;
		watchdog_trigger_ok <= 1'h1;
		cyc(1);
		watchdog_trigger_ok <= 1'h0;
		cyc(2);
		wr(ADDR_STATUS, 32'h0000_0001);
		cyc(3);
	endtask

	task automatic t_wd;
		config_sel <= 2'h2;
		wd_pulse;
		on(1'h0, "cfg3 first");
		rd(ADDR_STATUS, 32'h0000_000C, 32'h0000_0004, "wd count");
		wd_pulse;
		on(1'h1, "cfg3 second");
		wr(ADDR_STATUS, 32'h0000_0001);
		cyc(3);
		on(1'h1, "no trigger yet");
		wd_release;
		on(1'h0, "wd release");
		config_sel <= 2'h0;
		wd_pulse;
		on(1'h1, "cfg1 first");
		wd_release;
		config_sel <= 2'h1;
		wd_pulse;
		on(1'h0, "cfg2 first");
		rd(ADDR_STATUS, 32'h0000_0001, 32'h0000_0000, "cfg2 flag");
		mode <= MODE_SLEEP;
		cyc(3);
		mode <= MODE_NORMAL;
		rd(ADDR_STATUS, 32'h0000_000C, 32'h0000_0000, "sleep");
		wd_pulse;
		mode <= MODE_STOP;
		watchdog_off_in_stop <= 1'h1;
		cyc(3);
		mode <= MODE_NORMAL;
		watchdog_off_in_stop <= 1'h0;
		rd(ADDR_STATUS, 32'h0000_000C, 32'h0000_0000, "stop off");
		$display("test watchdog done");
	endtask

	task automatic wake_in(input fogl_mode_t m, input logic [1:0] w);
		mode <= m;
		wk <= w;
		cyc(20);
		wk <= 2'h0;
		cyc(20);
		mode <= MODE_NORMAL;
		cyc(2);
	endtask

	task automatic t_alt;
		int k;
		wr(ADDR_CTRL, 32'h0000_00A0);
		rd(ADDR_LEVEL, 32'h0000_0003, 32'h0000_0003, "levels");
		wake_in(MODE_NORMAL, 2'h1);
		rd(ADDR_WAKE, 32'h0000_0003, 32'h0000_0001, "wake");
		wr(ADDR_WAKE, 32'h0000_0003);
		rd(ADDR_WAKE, 32'h0000_0003, 32'h0000_0000, "wake clr");
		wake_in(MODE_RESTART, 2'h2);
		rd(ADDR_WAKE, 32'h0000_0003, 32'h0000_0002, "restart");
		wr(ADDR_WAKE, 32'h0000_0003);
		wake_in(MODE_FSAFE, 2'h3);
		rd(ADDR_WAKE, 32'h0000_0003, 32'h0000_0000, "fsafe");
		rd(ADDR_CTRL, 32'h0000_00F0, 32'h0000_00A0, "kept");
		mode <= MODE_STOP;
		cyc(2);
		wr(ADDR_CTRL, 32'h0000_0050);
		rd(ADDR_CTRL, 32'h0000_00F0, 32'h0000_00A0, "locked");
		mode <= MODE_NORMAL;
		cyc(2);
		wr(ADDR_CTRL, 32'h0000_0051);
		count_high(1'h1, 3 * BH, k);
		chk(32'(k), 32'h0000_0000, "pin off");
		on(1'h1, "static on");
		wr(ADDR_CTRL, 32'h0000_0050);
		wr(ADDR_CTRL, 32'h0000_03F0);
		cyc(2);
		chk({30'h0000_0000, pulsed_pin_hs_en, second_alt_pin_hs_en},
			32'h0000_0003, "high side");
		mode <= MODE_RESTART;
		cyc(2);
		chk({30'h0000_0000, pulsed_pin_hs_en, second_alt_pin_hs_en},
			32'h0000_0000, "restart off");
		mode <= MODE_NORMAL;
		cyc(2);
		chk({30'h0000_0000, pulsed_pin_hs_en, second_alt_pin_hs_en},
			32'h0000_0003, "resumed");
		wr(ADDR_CTRL, 32'h0000_00F0);
		cyc(2);
		chk({31'h0, blink_fail_out_n_oe}, 32'h0000_0001, "low side");
		wr(ADDR_CTRL, 32'h0000_0000);
		$display("test alternate done");
	endtask

	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		t_reset;
		t_force;
		t_src;
		t_uv;
		t_wd;
		t_alt;
		test_done;
	end
endmodule // tb
